// [rtl/tx_scale_pkg.sv]
// Shared constants, command codes and carrier structs for the transmit scaler
package tx_scale_pkg;

    // ========================================================
    // Command codes (host to device)
    // ========================================================
    localparam logic [7:0] CMD_OUTPUT_GAIN = 8'h10;
    localparam logic [7:0] CMD_MEM_READ    = 8'h20;
    localparam logic [7:0] CMD_MEM_WRITE   = 8'h21;
    localparam logic [7:0] CMD_EQ_SELECT   = 8'h30;

    // ========================================================
    // Reset values and memory map
    // ========================================================
    localparam logic [15:0] GAIN_RESET      = 16'h7FFF;
    localparam logic [1:0]  EQ_RESET        = 2'h0;
    localparam logic [15:0] TONE0_AMP_ADDR  = 16'h11EE;
    localparam logic [15:0] TONE1_AMP_ADDR  = 16'h11F1;
    localparam logic [15:0] TONE0_AMP_RESET = 16'h0F36;
    localparam logic [15:0] TONE1_AMP_RESET = 16'h137A;
    localparam logic [15:0] MEM_BASE        = 16'h11E8;
    localparam int          MEM_ADDR_W      = 4;

    // ========================================================
    // Equalizer emphasis coefficients, Q15, one per type
    // ========================================================
    localparam logic [15:0] EQ_K0 = 16'h0000;
    localparam logic [15:0] EQ_K1 = 16'h1000;
    localparam logic [15:0] EQ_K2 = 16'h2000;
    localparam logic [15:0] EQ_K3 = 16'h4000;

    // ========================================================
    // Carrier structs
    // ========================================================
    typedef struct packed {
        logic        valid;
        logic        start;
        logic [7:0]  data;
    } cmd_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  lo;
        logic [7:0]  hi;
    } reply_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] carrier;
        logic [15:0] tone0;
        logic [15:0] tone1;
    } sample_in_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } sample_out_t;

endpackage : tx_scale_pkg

// [rtl/tone_amp_mem.sv]
// Small data memory window holding the tone generator amplitude words
`timescale 1ns/100ps
`default_nettype none

module tone_amp_mem #(
    parameter logic [15:0] BASE   = tx_scale_pkg::MEM_BASE,
    parameter int          ADDR_W = tx_scale_pkg::MEM_ADDR_W
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata,
    output logic      [15:0] amp0,
    output logic      [15:0] amp1
);
    localparam int DEPTH = 1 << ADDR_W;

    typedef struct packed {
        logic [DEPTH-1:0][15:0] words;
        logic [15:0]            rdata;
    } mem_state_t;

    mem_state_t st_q;
    mem_state_t st_d;

    localparam logic [ADDR_W-1:0] IDX0 =
        ADDR_W'(tx_scale_pkg::TONE0_AMP_ADDR - BASE);
    localparam logic [ADDR_W-1:0] IDX1 =
        ADDR_W'(tx_scale_pkg::TONE1_AMP_ADDR - BASE);

    // Both amplitude words must fall inside the window
    if (ADDR_W < 1 || ADDR_W > 8
        || tx_scale_pkg::TONE0_AMP_ADDR < BASE
        || tx_scale_pkg::TONE1_AMP_ADDR < BASE
        || 32'(tx_scale_pkg::TONE1_AMP_ADDR - BASE) >= DEPTH
        || 32'(tx_scale_pkg::TONE0_AMP_ADDR - BASE) >= DEPTH) begin : g_bad
        $error("tone_amp_mem: window does not cover amplitude words");
    end

    function automatic logic in_window(input logic [15:0] a);
        in_window = (a >= BASE) && (32'(a - BASE) < DEPTH);
    endfunction : in_window

    logic [ADDR_W-1:0] idx;
    assign idx = ADDR_W'(addr - BASE);

    always_comb begin
        st_d = st_q;
        if (wr_en && in_window(addr)) begin
            st_d.words[idx] = wdata;
        end
        // Outside the window reads answer zero
        if (rd_en) begin
            st_d.rdata = in_window(addr) ? st_q.words[idx] : 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.words[IDX0] <= tx_scale_pkg::TONE0_AMP_RESET;
            st_q.words[IDX1] <= tx_scale_pkg::TONE1_AMP_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign amp0  = st_q.words[IDX0];
    assign amp1  = st_q.words[IDX1];

endmodule : tone_amp_mem
`default_nettype wire

// [rtl/transmit_level_scaler.sv]
// Transmit level scaler: command parser, tone mix, gain, equalizer
// Operation
// - Gain command stores value; later samples are multiplied by it.
// - One stored gain scales both carrier and tone generator output.
// - Gain is a signed two's-complement sixteen-bit value.
// - Gain resets to 7FFF, unity scaling.
// - Tone 0 amplitude lives at word 11EE, tone 1 at 11F1.
// - Memory read takes address low byte first; reply holds low then high.
// - Memory write takes address low, high, data low, high; stores word.
// - Tone level is generator amplitude further scaled by the gain.
// - Four equalizer types; type 0 front end only, 1-3 add cable.
`timescale 1ns/100ps
`default_nettype none

module transmit_level_scaler (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire tx_scale_pkg::cmd_t       cmd,
    input  wire tx_scale_pkg::sample_in_t sample_in,
    output tx_scale_pkg::reply_t          reply,
    output tx_scale_pkg::sample_out_t     sample_out,
    output logic [15:0]                   gain,
    output logic [1:0]                    eq_type
);
    // ========================================================
    // State
    // ========================================================
    typedef enum logic {PS_IDLE, PS_ARGS} parse_t;

    typedef struct packed {
        parse_t                   parse;
        logic [7:0]               opcode;
        logic [1:0]               argn;
        logic [7:0]               arg0;
        logic [7:0]               arg1;
        logic [7:0]               arg2;
        logic [15:0]              gain;
        logic [1:0]               eq;
        logic                     rd_pend;
        tx_scale_pkg::reply_t     reply;
        logic                     s1_valid;
        logic [15:0]              s1_sum;
        logic                     s2_valid;
        logic [15:0]              s2_val;
        logic [15:0]              eq_prev;
        tx_scale_pkg::sample_out_t out;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic        mem_wr;
    logic        mem_rd;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic [15:0] amp0;
    logic [15:0] amp1;

    // ========================================================
    // Helpers
    // ========================================================
    // Clamp a wide signed value to the sixteen-bit sample range
    function automatic logic [15:0] sat16(input logic signed [33:0] v);
        if (v > 34'sh7FFF) begin
            sat16 = 16'h7FFF;
        end else if (v < -34'sh8000) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // Q15 product, result saturated
    function automatic logic [15:0] qmul(input logic [15:0] a,
                                         input logic [15:0] b);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        qmul = sat16(34'(p >>> 15));
    endfunction : qmul

    // Wide Q15 product; wide operands keep the multiply from truncating
    function automatic logic signed [33:0] qprod(
        input logic signed [33:0] a,
        input logic signed [33:0] b
    );
        qprod = (a * b) >>> 15;
    endfunction : qprod

    function automatic logic [15:0] eq_coef(input logic [1:0] t);
        unique case (t)
            2'h0: eq_coef = tx_scale_pkg::EQ_K0;
            2'h1: eq_coef = tx_scale_pkg::EQ_K1;
            2'h2: eq_coef = tx_scale_pkg::EQ_K2;
            2'h3: eq_coef = tx_scale_pkg::EQ_K3;
        endcase
    endfunction : eq_coef

    // ========================================================
    // Amplitude memory
    // ========================================================
    tone_amp_mem #(
        .BASE   (tx_scale_pkg::MEM_BASE),
        .ADDR_W (tx_scale_pkg::MEM_ADDR_W)
    ) u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .wr_en (mem_wr),
        .rd_en (mem_rd),
        .addr  (mem_addr),
        .wdata (mem_wdata),
        .rdata (mem_rdata),
        .amp0  (amp0),
        .amp1  (amp1)
    );

    // ========================================================
    // Next state
    // ========================================================
    logic signed [33:0] mix;
    logic signed [33:0] sum;
    logic signed [16:0] diff;
    logic signed [33:0] emph;

    always_comb begin
        st_d      = st_q;
        mem_wr    = 1'b0;
        mem_rd    = 1'b0;
        mem_addr  = 16'h0000;
        mem_wdata = 16'h0000;
        st_d.reply.valid = 1'b0;
        st_d.rd_pend     = 1'b0;

        // Command bytes
        if (cmd.valid && cmd.start) begin
            st_d.opcode = cmd.data;
            st_d.argn   = 2'h0;
            st_d.parse  = PS_ARGS;
        end else if (cmd.valid && st_q.parse == PS_ARGS) begin
            st_d.argn = st_q.argn + 2'h1;
            unique case (st_q.argn)
                2'h0: st_d.arg0 = cmd.data;
                2'h1: st_d.arg1 = cmd.data;
                2'h2: st_d.arg2 = cmd.data;
                2'h3: ;
            endcase
            unique case (st_q.opcode)
                tx_scale_pkg::CMD_OUTPUT_GAIN: begin
                    if (st_q.argn == 2'h1) begin
                        st_d.gain  = {cmd.data, st_q.arg0};
                        st_d.parse = PS_IDLE;
                    end
                end
                tx_scale_pkg::CMD_EQ_SELECT: begin
                    st_d.eq    = cmd.data[1:0];
                    st_d.parse = PS_IDLE;
                end
                tx_scale_pkg::CMD_MEM_READ: begin
                    if (st_q.argn == 2'h1) begin
                        mem_rd       = 1'b1;
                        mem_addr     = {cmd.data, st_q.arg0};
                        st_d.rd_pend = 1'b1;
                        st_d.parse   = PS_IDLE;
                    end
                end
                tx_scale_pkg::CMD_MEM_WRITE: begin
                    if (st_q.argn == 2'h3) begin
                        mem_wr     = 1'b1;
                        mem_addr   = {st_q.arg1, st_q.arg0};
                        mem_wdata  = {cmd.data, st_q.arg2};
                        st_d.parse = PS_IDLE;
                    end
                end
                // Unknown codes swallow bytes until the next start
                default: ;
            endcase
        end

        if (st_q.rd_pend) begin
            st_d.reply.valid = 1'b1;
            st_d.reply.lo    = mem_rdata[7:0];
            st_d.reply.hi    = mem_rdata[15:8];
        end

        // Stage 1: tones weighted by their amplitude words, plus carrier
        mix = qprod(34'($signed(sample_in.tone0)), 34'($signed(amp0)))
            + qprod(34'($signed(sample_in.tone1)), 34'($signed(amp1)));
        sum = 34'($signed(sample_in.carrier)) + 34'($signed(sat16(mix)));
        st_d.s1_valid = sample_in.valid;
        if (sample_in.valid) begin
            st_d.s1_sum = sat16(sum);
        end

        // Stage 2: one gain for carrier and tones alike
        st_d.s2_valid = st_q.s1_valid;
        if (st_q.s1_valid) begin
            st_d.s2_val = qmul(st_q.s1_sum, st_q.gain);
        end

        // Stage 3: emphasis grows with cable length type
        diff = 17'($signed(st_q.s2_val)) - 17'($signed(st_q.eq_prev));
        emph = qprod(34'(diff), 34'($signed(eq_coef(st_q.eq))));
        st_d.out.valid = st_q.s2_valid;
        if (st_q.s2_valid) begin
            st_d.out.data = sat16(34'($signed(st_q.s2_val)) + emph);
            st_d.eq_prev  = st_q.s2_val;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q       <= '0;
            st_q.parse <= PS_IDLE;
            st_q.gain  <= tx_scale_pkg::GAIN_RESET;
            st_q.eq    <= tx_scale_pkg::EQ_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign reply      = st_q.reply;
    assign sample_out = st_q.out;
    assign gain       = st_q.gain;
    assign eq_type    = st_q.eq;

endmodule : transmit_level_scaler
`default_nettype wire

// [verif/tx_scale_chk_asserts.sv]
// Port checker for the transmit level scaler
`timescale 1ns/100ps
`default_nettype none
module tx_scale_chk (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire tx_scale_pkg::cmd_t        cmd,
    input wire tx_scale_pkg::sample_in_t  sample_in,
    input wire tx_scale_pkg::reply_t      reply,
    input wire tx_scale_pkg::sample_out_t sample_out,
    input wire logic [15:0]               gain,
    input wire logic [1:0]                eq_type
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ====================================================
    // Properties
    chk_gain_reset: assert property (
        $rose(rst_n) |-> gain == 16'h7FFF)
        else $error("gain not at reset value");
    chk_gain_cause: assert property (
        !$stable(gain) |-> $past(cmd.valid))
        else $error("gain changed without a command byte");
    chk_eq_cause: assert property (
        !$stable(eq_type) |-> $past(cmd.valid))
        else $error("equalizer type changed without a command byte");
    chk_out_latency: assert property (
        sample_in.valid |-> ##3 sample_out.valid)
        else $error("sample out missing three cycles after input");
    chk_out_cause: assert property (
        sample_out.valid |-> $past(sample_in.valid, 3))
        else $error("sample out without an input sample");
    chk_out_hold: assert property (
        !sample_out.valid |-> $stable(sample_out.data))
        else $error("sample data moved between samples");
    chk_reply_pulse: assert property (
        reply.valid |=> !reply.valid)
        else $error("reply valid longer than one cycle");
    chk_reply_cause: assert property (
        reply.valid |-> $past(cmd.valid, 2))
        else $error("reply without an address byte two cycles back");
    chk_reply_hold: assert property (
        !reply.valid |-> $stable({reply.lo, reply.hi}))
        else $error("reply bytes moved without a read");
endmodule : tx_scale_chk
bind transmit_level_scaler tx_scale_chk u_tx_scale_chk (
    .clk(clk), .rst_n(rst_n), .cmd(cmd), .sample_in(sample_in),
    .reply(reply), .sample_out(sample_out), .gain(gain), .eq_type(eq_type)
);
`default_nettype wire

// [verif/host_model.sv]
// Host model that sends command bytes and collects replies
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic                 clk,
    input  wire tx_scale_pkg::reply_t reply,
    output var tx_scale_pkg::cmd_t    cmd
);
    initial cmd = '0;
    task automatic put(input logic st, input logic [7:0] d);
        @(negedge clk);
        cmd = '{1'b1, st, d};
        @(negedge clk);
        // Idle byte inverted so a stale value is never reused
        cmd = '{1'b0, 1'b0, ~d};
    endtask : put
    task automatic set_gain(input logic [15:0] g);
        put(1'b1, tx_scale_pkg::CMD_OUTPUT_GAIN);
        put(1'b0, g[7:0]);
        put(1'b0, g[15:8]);
    endtask : set_gain
    task automatic set_eq(input logic [1:0] t);
        put(1'b1, tx_scale_pkg::CMD_EQ_SELECT);
        put(1'b0, {6'h00, t});
    endtask : set_eq
    task automatic mem_rd(input logic [15:0] a, output logic [15:0] w);
        w = 16'hxxxx;
        put(1'b1, tx_scale_pkg::CMD_MEM_READ);
        put(1'b0, a[7:0]);
        put(1'b0, a[15:8]);
        repeat (6) begin
            @(negedge clk);
            if (reply.valid === 1'b1) w = {reply.hi, reply.lo};
        end
    endtask : mem_rd
    task automatic mem_wr(input logic [15:0] a, input logic [15:0] d);
        put(1'b1, tx_scale_pkg::CMD_MEM_WRITE);
        put(1'b0, a[7:0]);
        put(1'b0, a[15:8]);
        put(1'b0, d[7:0]);
        put(1'b0, d[15:8]);
    endtask : mem_wr
endmodule : host_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the transmit level scaler
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk;
    logic rst_n;
    tx_scale_pkg::cmd_t cmd;
    tx_scale_pkg::sample_in_t sample_in;
    tx_scale_pkg::reply_t reply;
    tx_scale_pkg::sample_out_t sample_out;
    logic [15:0] gain, rnd, amp0, amp1, gn, w, exp_out;
    logic [1:0] eq_type, eqt;
    logic signed [39:0] gp;
    int miscompares, tests_run, cycles;
    logic [15:0] kt [4] = '{tx_scale_pkg::EQ_K0, tx_scale_pkg::EQ_K1,
                            tx_scale_pkg::EQ_K2, tx_scale_pkg::EQ_K3};
    logic [15:0] gl [4] = '{16'h65AC, 16'h8000, 16'hFFFF, 16'h0000};
    transmit_level_scaler u_transmit_level_scaler (.clk(clk),
        .rst_n(rst_n), .cmd(cmd), .sample_in(sample_in), .reply(reply),
        .sample_out(sample_out), .gain(gain), .eq_type(eq_type));
    host_model u_host_model (.clk(clk), .reply(reply), .cmd(cmd));
    // ====================================================
    // Expectation helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic signed [39:0] sat(input logic signed [39:0] x);
        return (x > 40'sh7FFF) ? 40'sh7FFF : (x < -40'sh8000) ? -40'sh8000 : x;
    endfunction : sat
    function automatic logic [15:0] model(input tx_scale_pkg::sample_in_t s);
        logic signed [39:0] m, g;
        m = sat((($signed(s.tone0) * $signed(amp0)) >>> 15)
              + (($signed(s.tone1) * $signed(amp1)) >>> 15));
        m = sat($signed(s.carrier) + m);
        g = sat((m * $signed(gn)) >>> 15);
        m = sat(g + (((g - gp) * $signed(kt[eqt])) >>> 15));
        gp = g;
        return m[15:0];
    endfunction : model
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic run_sample(input logic [15:0] c, input logic [15:0] t);
        tx_scale_pkg::sample_in_t s;
        s = '{1'b1, c, t, ~t};
        exp_out = model(s);
        @(negedge clk);
        sample_in = s;
        @(negedge clk);
        sample_in.valid = 1'b0;
        repeat (2) @(negedge clk);
        check({15'h0, sample_out.valid}, 16'h0001);
        check(sample_out.data, exp_out);
    endtask : run_sample
    task report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // ====================================================
    // Clock, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        rst_n = 1'b0;
        sample_in = '0;
        rnd = 16'h0002;
        amp0 = 16'h0F36;
        amp1 = 16'h137A;
        gn = 16'h7FFF;
        gp = '0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        check(gain, 16'h7FFF);
        check({14'h0, eq_type}, 16'h0000);
        u_host_model.mem_rd(16'h11EE, w);
        check(w, 16'h0F36);
        u_host_model.mem_rd(16'h11F1, w);
        check(w, 16'h137A);
        u_host_model.mem_rd(16'h2000, w);
        check(w, 16'h0000);
        $display("test default reads done");
        for (int e = 0; e < 4; e++) begin
            eqt = e[1:0];
            u_host_model.set_eq(eqt);
            check({14'h0, eq_type}, {14'h0, eqt});
            repeat (6) begin
                rnd = lfsr(rnd);
                run_sample(rnd, lfsr(rnd));
            end
        end
        $display("test equalizer types done");
        amp0 = 16'h1A50;
        amp1 = 16'h21B1;
        u_host_model.mem_wr(16'h11EE, amp0);
        u_host_model.mem_wr(16'h11F1, amp1);
        u_host_model.mem_rd(16'h11EE, w);
        check(w, amp0);
        u_host_model.mem_rd(16'h11F1, w);
        check(w, amp1);
        $display("test amplitude writes done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            gn = (i < 4) ? gl[i] : rnd;
            u_host_model.set_gain(gn);
            check(gain, gn);
            run_sample(16'h7FFF, 16'h7FFF);
            repeat (4) begin
                rnd = lfsr(rnd);
                run_sample(rnd, lfsr(rnd));
            end
        end
        $display("test gain settings done");
        // Stray bytes, an unknown opcode and a cut command change nothing
        u_host_model.put(1'b0, 8'h3C);
        u_host_model.put(1'b1, 8'h7E);
        u_host_model.put(1'b0, 8'h55);
        u_host_model.put(1'b1, tx_scale_pkg::CMD_OUTPUT_GAIN);
        u_host_model.put(1'b0, 8'h12);
        u_host_model.set_eq(2'h2);
        check(gain, gn);
        check({14'h0, eq_type}, 16'h0002);
        $display("test stray commands done");
        // Second reset mid-run: every default comes back
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        gn = 16'h7FFF;
        gp = '0;
        eqt = 2'h0;
        amp0 = 16'h0F36;
        amp1 = 16'h137A;
        check(gain, 16'h7FFF);
        check({14'h0, eq_type}, 16'h0000);
        u_host_model.mem_rd(16'h11EE, w);
        check(w, 16'h0F36);
        rnd = lfsr(rnd);
        run_sample(rnd, lfsr(rnd));
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
